// ===== logic/lmfc_sync_consts.svh
// Register offsets, field positions, mode codes and reset values for LMFC sync status
`ifndef LMFC_SYNC_CONSTS_SVH
`define LMFC_SYNC_CONSTS_SVH

// Byte addresses on the register bus
`define OFS_CONTROL 12'h000
`define OFS_PULSE_DELAY 12'h004
`define OFS_PULSE_COUNT 12'h008
`define OFS_WINDOW 12'h00c
`define OFS_STATE_FLAGS 12'h010
`define OFS_PHASE_LOW 12'h014
`define OFS_PHASE_HIGH 12'h018
`define OFS_IRQ_STATUS 12'h01c
`define OFS_IRQ_MASK 12'h020

// Control register fields
`define CTL_ENABLE_BIT 7
`define CTL_ARM_BIT 6
`define CTL_CLR_STICKY_BIT 5
`define CTL_MODE_MSB 3

// Status flag positions
`define FLAG_BUSY_BIT 7
`define FLAG_LOCKED_BIT 3
`define FLAG_ROTATED_BIT 2
`define FLAG_WINDOW_BIT 1
`define FLAG_TRIPPED_BIT 0

// Mode codes
`define MODE_CONTINUOUS 4'h2
`define MODE_MONITOR 4'h8
`define MODE_ONESHOT_MON 4'h9

// Interrupt event positions
`define EV_ROTATE_BIT 0
`define EV_TRIP_BIT 1
`define EV_WINDOW_BIT 2
`define EV_WIDTH 3

`define RESET_BYTE 8'h00
`define RESET_WINDOW 8'h01

`endif

// ===== logic/lmfc_sync_pkg.sv
// Types for the LMFC sync status block
package lmfc_sync_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_ALIGN = 2'b10,
    ST_MONITOR = 2'b11
  } align_state_t;
  typedef logic [8:0] phase_err_t;
endpackage

// ===== logic/lmfc_sync_status.sv
// LMFC to reference pulse alignment with status registers on APB
//
// Functional notes
// - Mode 0010 continuous, 1000 monitor, 1001 once-then-monitor
// - Status bit 7 high while machine busy
// - Status bit 3 set when aligned within window
// - Status bit 2 sticky after a rotation
// - Status bit 1 high while error outside window
// - Status bit 0 sticky on pulse after arming
// - Phase error is 9-bit signed DAC clock count
// - Sticky clear rising edge clears rotated, tripped
// - Pulse mode rotates after configured pulse count
// - Pulse mode waits configured LMFC counts first
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "lmfc_sync_consts.svh"

module lmfc_sync_status #(
  parameter int LMFC_PERIOD = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sysref_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic lmfc_edge_out,
  output logic irq_out
);
  import lmfc_sync_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  lmfc_sync_pkg::align_state_t state_reg;
  logic [7:0] control_reg;
  logic [7:0] pulse_active_delay;
  logic [7:0] pulse_rotate_count;
  logic [7:0] window_reg;
  logic [`EV_WIDTH-1:0] irq_status_reg;
  logic [`EV_WIDTH-1:0] irq_mask_reg;
  logic [7:0] lmfc_cnt_reg;
  logic [7:0] delay_cnt_reg;
  logic [7:0] ref_cnt_reg;
  logic armed_reg;
  logic align_locked_flag;
  logic rotated_sticky_flag;
  logic window_exceeded_flag;
  logic tripped_sticky_flag;
  phase_err_t phase_err_reg;
  logic sync_meta_reg;
  logic sync_ref_reg;
  logic sync_prev_reg;
  logic clr_prev_reg;
  logic [3:0] align_mode_select;
  logic sync_enable;
  logic align_busy_flag;
  logic sysref_rise;
  logic wr_en;
  logic sticky_clear_strobe;
  logic rotate_now;
  logic arm_now;
  phase_err_t phase_meas;
  logic [8:0] phase_mag;
  logic outside_window;
  logic [`EV_WIDTH-1:0] ev_set;
  logic [7:0] phase_error_low_byte;
  logic phase_error_under_flag;

  assign align_mode_select = control_reg[`CTL_MODE_MSB:0];
  assign sync_enable = control_reg[`CTL_ENABLE_BIT];
  assign phase_error_low_byte = phase_err_reg[7:0];
  assign phase_error_under_flag = phase_err_reg[8];

  // ----------------------------------------------------------------
  // Reference pulse synchroniser and edge detection
  // ----------------------------------------------------------------
  // Two stages before any logic; only the second stage feeds the edge detector
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_meta_reg <= 1'b0;
      sync_ref_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      sync_meta_reg <= sysref_in;
      sync_ref_reg <= sync_meta_reg;
      sync_prev_reg <= sync_ref_reg;
    end
  end
  assign sysref_rise = sync_ref_reg & ~sync_prev_reg;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  assign pready_out = 1'b1;
  assign wr_en = psel_in & penable_in & pwrite_in;

  // Error answered combinationally in the access phase
  always_comb begin
    pslverr_out = 1'b0;
    if (psel_in && penable_in) begin
      if (paddr_in == `OFS_CONTROL) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_PULSE_DELAY) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_PULSE_COUNT) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_WINDOW) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_STATE_FLAGS) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_PHASE_LOW) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_PHASE_HIGH) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_IRQ_STATUS) pslverr_out = 1'b0;
      else if (paddr_in == `OFS_IRQ_MASK) pslverr_out = 1'b0;
      else pslverr_out = 1'b1;
    end
  end

  // Software-written settings
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      control_reg <= `RESET_BYTE;
      pulse_active_delay <= `RESET_BYTE;
      pulse_rotate_count <= `RESET_BYTE;
      window_reg <= `RESET_WINDOW;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (paddr_in == `OFS_CONTROL) control_reg <= pwdata_in[7:0];
      else if (paddr_in == `OFS_PULSE_DELAY) pulse_active_delay <= pwdata_in[7:0];
      else if (paddr_in == `OFS_PULSE_COUNT) pulse_rotate_count <= pwdata_in[7:0];
      else if (paddr_in == `OFS_WINDOW) window_reg <= pwdata_in[7:0];
      else if (paddr_in == `OFS_IRQ_MASK) irq_mask_reg <= pwdata_in[`EV_WIDTH-1:0];
    end
  end

  // Read data registered so it is stable for the whole access phase
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      if (paddr_in == `OFS_CONTROL) prdata_out <= {24'h0, control_reg};
      else if (paddr_in == `OFS_PULSE_DELAY) prdata_out <= {24'h0, pulse_active_delay};
      else if (paddr_in == `OFS_PULSE_COUNT) prdata_out <= {24'h0, pulse_rotate_count};
      else if (paddr_in == `OFS_WINDOW) prdata_out <= {24'h0, window_reg};
      else if (paddr_in == `OFS_STATE_FLAGS) prdata_out <= {24'h0, align_busy_flag,
        3'h0, align_locked_flag, rotated_sticky_flag, window_exceeded_flag,
        tripped_sticky_flag};
      else if (paddr_in == `OFS_PHASE_LOW) prdata_out <= {24'h0, phase_error_low_byte};
      else if (paddr_in == `OFS_PHASE_HIGH) prdata_out <= {31'h0, phase_error_under_flag};
      else if (paddr_in == `OFS_IRQ_STATUS) prdata_out <= {29'h0, irq_status_reg};
      else if (paddr_in == `OFS_IRQ_MASK) prdata_out <= {29'h0, irq_mask_reg};
      else prdata_out <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Control strobes: sticky clear acts on a rising edge, arm on any control write with the arm bit set
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clr_prev_reg <= 1'b0;
    end else begin
      clr_prev_reg <= control_reg[`CTL_CLR_STICKY_BIT];
    end
  end
  assign sticky_clear_strobe = control_reg[`CTL_CLR_STICKY_BIT] & ~clr_prev_reg;
  assign arm_now = wr_en && (paddr_in == `OFS_CONTROL) && pwdata_in[`CTL_ARM_BIT];

  // ----------------------------------------------------------------
  // Local multiframe counter and phase measurement
  // ----------------------------------------------------------------
  // Counter wraps each multiframe; a rotation restarts it on the pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lmfc_cnt_reg <= 8'h0;
    end else if (rotate_now || lmfc_cnt_reg == 8'(LMFC_PERIOD - 1)) begin
      lmfc_cnt_reg <= 8'h0;
    end else begin
      lmfc_cnt_reg <= lmfc_cnt_reg + 8'h1;
    end
  end
  assign lmfc_edge_out = (lmfc_cnt_reg == 8'h0);

  // Signed distance to the nearest edge: late is positive, early negative
  always_comb begin
    if ({1'b0, lmfc_cnt_reg} < 9'(LMFC_PERIOD / 2)) begin
      phase_meas = {1'b0, lmfc_cnt_reg};
    end else begin
      phase_meas = {1'b0, lmfc_cnt_reg} - 9'(LMFC_PERIOD);
    end
    phase_mag = phase_meas[8] ? (9'h0 - phase_meas) : phase_meas;
  end
  assign outside_window = phase_mag > {1'b0, window_reg};

  // Capture on each pulse while enabled, held for reads until the next one
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_err_reg <= 9'h0;
    end else if (sysref_rise && sync_enable) begin
      phase_err_reg <= phase_meas;
    end
  end

  // ----------------------------------------------------------------
  // Alignment state machine
  // ----------------------------------------------------------------
  assign rotate_now = (state_reg == ST_ALIGN) && sysref_rise &&
                      (ref_cnt_reg + 8'h1 >= pulse_rotate_count);
  assign align_busy_flag = (state_reg == ST_WAIT) || (state_reg == ST_ALIGN);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      delay_cnt_reg <= 8'h0;
      ref_cnt_reg <= 8'h0;
    end else if (!sync_enable) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          delay_cnt_reg <= 8'h0;
          ref_cnt_reg <= 8'h0;
          if (align_mode_select == `MODE_MONITOR) begin
            state_reg <= ST_MONITOR;
          end else if (align_mode_select == `MODE_CONTINUOUS ||
                       (align_mode_select == `MODE_ONESHOT_MON && armed_reg)) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Delay counted in multiframes before pulses are trusted
          if (delay_cnt_reg >= pulse_active_delay) begin
            state_reg <= ST_ALIGN;
          end else if (lmfc_edge_out) begin
            delay_cnt_reg <= delay_cnt_reg + 8'h1;
          end
        end
        ST_ALIGN: begin
          if (rotate_now) begin
            ref_cnt_reg <= 8'h0;
            state_reg <= (align_mode_select == `MODE_CONTINUOUS) ? ST_WAIT
                                                                 : ST_MONITOR;
            delay_cnt_reg <= 8'h0;
          end else if (sysref_rise) begin
            ref_cnt_reg <= ref_cnt_reg + 8'h1;
          end
        end
        ST_MONITOR: begin
          if (align_mode_select != `MODE_MONITOR &&
              align_mode_select != `MODE_ONESHOT_MON) begin
            state_reg <= ST_IDLE;
          end else if (align_mode_select == `MODE_ONESHOT_MON && arm_now) begin
            state_reg <= ST_WAIT;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Arm stays until the next pulse trips it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      armed_reg <= 1'b0;
    end else if (arm_now) begin
      armed_reg <= 1'b1;
    end else if (sysref_rise && sync_enable) begin
      armed_reg <= 1'b0;
    end
  end

  // Sticky flags: a set in the clear cycle wins so no event is lost
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rotated_sticky_flag <= 1'b0;
      tripped_sticky_flag <= 1'b0;
    end else begin
      if (rotate_now) rotated_sticky_flag <= 1'b1;
      else if (sticky_clear_strobe) rotated_sticky_flag <= 1'b0;
      if (armed_reg && sysref_rise && sync_enable) tripped_sticky_flag <= 1'b1;
      else if (sticky_clear_strobe) tripped_sticky_flag <= 1'b0;
    end
  end

  // Lock and window flags follow the last measured pulse
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      align_locked_flag <= 1'b0;
      window_exceeded_flag <= 1'b0;
    end else if (!sync_enable) begin
      align_locked_flag <= 1'b0;
      window_exceeded_flag <= 1'b0;
    end else if (sysref_rise) begin
      align_locked_flag <= rotate_now | ~outside_window;
      window_exceeded_flag <= ~rotate_now & outside_window;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: write one to clear, set wins
  // ----------------------------------------------------------------
  // Window event on every non-rotating measured pulse outside the window, not only on repeats
  assign ev_set = {sysref_rise & sync_enable & ~rotate_now & outside_window,
                   armed_reg & sysref_rise & sync_enable, rotate_now};
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= ev_set | (irq_status_reg &
        ~((wr_en && paddr_in == `OFS_IRQ_STATUS) ? pwdata_in[`EV_WIDTH-1:0] : 3'h0));
    end
  end
  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence rot_seq;
    rotate_now ##1 1'b1;
  endsequence

  chk_rotate_sticky: assert property (rot_seq |-> rotated_sticky_flag)
    else $error("rotated flag not set after rotation");
  chk_trip_sticky: assert property (armed_reg && sysref_rise && sync_enable
    |=> tripped_sticky_flag) else $error("tripped flag not set");
  chk_clear_sticky: assert property (sticky_clear_strobe && !rotate_now && !sysref_rise
    |=> !rotated_sticky_flag) else $error("sticky clear failed");
  chk_busy_flag: assert property (!sync_enable |=> !align_busy_flag)
    else $error("busy high while disabled");
  chk_phase_hold: assert property (!sysref_rise |=> $stable(phase_err_reg))
    else $error("phase error changed without pulse");
  chk_phase_cap: assert property (sysref_rise && sync_enable |=>
    phase_err_reg == $past(phase_meas)) else $error("phase not captured");
  chk_window_lock: assert property (sync_enable && sysref_rise && !rotate_now
    |=> window_exceeded_flag != align_locked_flag) else $error("lock flags disagree");
  chk_monitor_mode: assert property (state_reg == ST_MONITOR && sync_enable &&
    align_mode_select == `MODE_MONITOR |=> state_reg == ST_MONITOR)
    else $error("monitor mode left");
  chk_wait_delay: assert property (state_reg == ST_WAIT && sync_enable &&
    delay_cnt_reg < pulse_active_delay |=> state_reg != ST_ALIGN)
    else $error("align entered before delay");
  chk_pulse_rotate_count: assert property (rotate_now |-> ref_cnt_reg + 8'h1 >= pulse_rotate_count)
    else $error("rotation before pulse count");
  chk_ref_count: assert property (state_reg == ST_ALIGN && sync_enable && sysref_rise
    && !rotate_now |=> ref_cnt_reg == $past(ref_cnt_reg) + 8'h1)
    else $error("reference pulse not counted");

endmodule // lmfc_sync_status

// ===== tb/sysref_source.sv
// Reference pulse source model driving the block's sysref input
`timescale 1ns/1ps

module sysref_source (
  input wire logic clk_in,
  input wire logic fire_in,
  output logic sysref_out
);
  int hi_cnt = 0;

  // -----------------------------
  // Pulse generator
  // -----------------------------
  // Fixed launch latency, so phase offsets seen by the block follow the request timing
  always @(posedge clk_in) begin
    if (hi_cnt > 0) begin
      hi_cnt <= hi_cnt - 1;
    end else if (fire_in) begin
      hi_cnt <= 4; // Four cycles high keeps the synchroniser happy
    end
  end
  // Idle low between pulses
  assign sysref_out = (hi_cnt > 0);
endmodule // sysref_source

// ===== tb/tb.sv
// Self-checking testbench for the LMFC sync status block
`timescale 1ns/1ps
`include "lmfc_sync_consts.svh"

module tb;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic lmfc_edge_out;
  logic irq_out;
  logic sysref;
  logic fire = 1'b0;
  logic last_err;
  int error_cnt = 0;
  int n_tests = 0;

  // -----------------------------
  // Clock, design and partner
  // -----------------------------
  always #25 clk_in = ~clk_in;

  lmfc_sync_status #(.LMFC_PERIOD(32)) u_lmfc_sync_status (
    .clk_in(clk_in), .nrst_in(nrst_in), .sysref_in(sysref), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .lmfc_edge_out(lmfc_edge_out), .irq_out(irq_out)
  );

  sysref_source u_sysref_source (.clk_in(clk_in), .fire_in(fire), .sysref_out(sysref));

  // -----------------------------
  // Shared tasks
  // -----------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready at the sampling edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    last_err = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    apb(1'b1, a, {24'h0, d}, rd);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    apb(1'b0, a, 32'h0, rd);
    chk(name, rd, exp);
  endtask

  // Fire a pulse k cycles after a multiframe edge, then let the flags settle
  task automatic pulse(input int k);
    do @(posedge clk_in); while (lmfc_edge_out !== 1'b1);
    repeat (k) @(posedge clk_in);
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    repeat (12) @(posedge clk_in);
  endtask

  task automatic phase(output logic [8:0] p);
    logic [31:0] lo;
    logic [31:0] hi;
    apb(1'b0, `OFS_PHASE_LOW, 32'h0, lo);
    apb(1'b0, `OFS_PHASE_HIGH, 32'h0, hi);
    p = {hi[0], lo[7:0]};
  endtask

  // Sticky clear wants a rising edge, so drop the bit first
  task automatic clear_sticky(input logic [7:0] ctl);
    wr(`OFS_CONTROL, ctl);
    wr(`OFS_CONTROL, ctl | 8'h20);
    wr(`OFS_CONTROL, ctl);
  endtask

  // -----------------------------
  // Scenarios
  // -----------------------------
  task automatic t_reset;
    logic [31:0] rd;
    int n = 0;
    rd_chk("flags", `OFS_STATE_FLAGS, 32'h0);
    rd_chk("phase_low", `OFS_PHASE_LOW, 32'h0);
    rd_chk("window", `OFS_WINDOW, 32'h1);
    apb(1'b0, 12'h0f0, 32'h0, rd);
    chk("unmapped_err", {31'h0, last_err}, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    // One multiframe edge every 32 cycles
    do @(posedge clk_in); while (lmfc_edge_out !== 1'b1);
    do begin
      @(posedge clk_in);
      n++;
    end while (lmfc_edge_out !== 1'b1);
    chk("lmfc_period", n, 32'h20);
  endtask

  // Monitor mode measures but never rotates; differences cancel the fixed latency
  task automatic t_monitor;
    logic [8:0] p1;
    logic [8:0] p2;
    logic [8:0] p3;
    logic [31:0] f;
    wr(`OFS_CONTROL, 8'h88);
    pulse(2);
    phase(p1);
    pulse(5);
    phase(p2);
    chk("phase_step", {23'h0, p2 - p1}, 32'h3);
    pulse(20);
    phase(p3);
    chk("phase_wrap", {23'h0, p3 - p1}, 32'h1f2);
    chk("phase_sign", {31'h0, p3[8]}, 32'h1);
    repeat (40) @(posedge clk_in);
    phase(p2);
    chk("phase_held", {23'h0, p2}, {23'h0, p3});
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("no_rotate", {31'h0, f[2]}, 32'h0);
    chk("window_flag", {31'h0, f[1]}, 32'h1);
    chk("not_locked", {31'h0, f[3]}, 32'h0);
  endtask

  // Arm, trip, interrupt masking and W1C
  task automatic t_trip;
    logic [31:0] f;
    wr(`OFS_CONTROL, 8'hc8);
    wr(`OFS_CONTROL, 8'h88);
    pulse(3);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("tripped", {31'h0, f[0]}, 32'h1);
    chk("irq_masked", {31'h0, irq_out}, 32'h0);
    // The level follows the register combinationally, from the edge the write lands
    wr(`OFS_IRQ_MASK, 8'h02);
    @(posedge clk_in);
    chk("irq_on", {31'h0, irq_out}, 32'h1);
    wr(`OFS_IRQ_STATUS, 8'h02);
    @(posedge clk_in);
    chk("irq_off", {31'h0, irq_out}, 32'h0);
    pulse(3);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("trip_sticky", {31'h0, f[0]}, 32'h1);
    clear_sticky(8'h88);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("trip_clr", {31'h0, f[0]}, 32'h0);
    wr(`OFS_IRQ_MASK, 8'h00);
  endtask

  // Continuous mode rotates; one-shot mode rotates only after arming, then monitors
  task automatic t_rotate;
    logic [31:0] f;
    wr(`OFS_CONTROL, 8'h82);
    pulse(7);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("cont_rot", {31'h0, f[2]}, 32'h1);
    rd_chk("irq_rot", `OFS_IRQ_STATUS, 32'h5);
    // Leave the running alignment through a disable before choosing one-shot mode
    clear_sticky(8'h09);
    wr(`OFS_CONTROL, 8'h89);
    pulse(7);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("once_idle", {31'h0, f[2]}, 32'h0);
    wr(`OFS_CONTROL, 8'hc9);
    wr(`OFS_CONTROL, 8'h89);
    pulse(7);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("once_rot", {31'h0, f[2]}, 32'h1);
    clear_sticky(8'h89);
    pulse(9);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("once_mon", {31'h0, f[2]}, 32'h0);
  endtask

  // Pulse count and multiframe delay both hold off the rotation
  task automatic t_counts;
    logic [31:0] f;
    wr(`OFS_PULSE_COUNT, 8'h02);
    wr(`OFS_CONTROL, 8'h82);
    pulse(7);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("count_hold", {31'h0, f[2]}, 32'h0);
    chk("busy_align", {31'h0, f[7]}, 32'h1);
    pulse(7);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("count_rot", {31'h0, f[2]}, 32'h1);
    clear_sticky(8'h02);
    wr(`OFS_PULSE_COUNT, 8'h00);
    wr(`OFS_PULSE_DELAY, 8'h04);
    wr(`OFS_CONTROL, 8'h82);
    pulse(7);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("delay_hold", {31'h0, f[2]}, 32'h0);
    chk("busy_wait", {31'h0, f[7]}, 32'h1);
    repeat (160) @(posedge clk_in);
    pulse(7);
    apb(1'b0, `OFS_STATE_FLAGS, 32'h0, f);
    chk("delay_rot", {31'h0, f[2]}, 32'h1);
  endtask

  // -----------------------------
  // Main sequence and verdict
  // -----------------------------
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_monitor();
    t_trip();
    t_rotate();
    t_counts();
    conclude();
  end

  // Generous bound: the scenarios need about 800 cycles of the 20000
  initial begin
    #(50 * 20000);
    error_cnt++;
    conclude();
  end
endmodule // tb
